// ---- fp_compare_convert_unit.sv ----
// floating-point compare and float-to-integer convert execution unit
//
// Operation
// - ordered compare (63/32) compares double operand A against operand B
// - unordered compare (63/0) compares double operand A against operand B
// - compares set the status condition code and copy it to selected CR field
// - any NaN compare operand gives the unordered condition code
// - any signaling NaN compare operand sets the signaling-NaN invalid flag
// - ordered compare with signaling NaN and invalid disabled sets invalid-compare
// - ordered compare with quiet NaN operand sets invalid-compare flag
// - unordered compare touches only condition code, signaling-NaN flag and the FX, VX and FEX summaries
// - convert 814 gives 64-bit signed integer using the rounding-control field
// - convert 815 gives 64-bit signed integer rounding toward zero always
// - doubleword converts saturate to maximum or most negative 64-bit value
// - doubleword converts set rounded and inexact flags; class field left alone
// - doubleword converts update flags; record bit copies summaries to field 1
// - doubleword converts are illegal instructions on 32-bit builds
// - convert 14 gives 32-bit integer in low word using rounding-control field
// - word convert saturates low word to 0x7FFFFFFF or 0x80000000
// - word convert updates status; record bit copies summaries to field 1
module fp_compare_convert_unit #(
  parameter bit IS_64BIT = 1'b1
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // instruction issue
  input  wire logic        i_issue_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [63:0] i_src_a,
  input  wire logic [63:0] i_src_b,
  // register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  // completion and write-back
  output logic             o_done,
  output logic             o_illegal,
  output logic             o_result_we,
  output logic      [4:0]  o_result_idx,
  output logic      [63:0] o_result,
  output logic             o_cc_we,
  output logic      [2:0]  o_cc_field,
  output logic      [3:0]  o_cc_data,
  output logic             o_cr1_we,
  output logic      [3:0]  o_cr1_data,
  // status
  output logic      [31:0] o_fp_status,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // operand classification
  // ----------------------------------------------------------------
  function automatic logic is_nan(input logic [63:0] v);
    return (v[62:52] == fp_cmp_cvt_pkg::EXP_ALL) && (v[51:0] != 52'h0);
  endfunction

  function automatic logic is_signaling_not_a_number(input logic [63:0] v);
    return is_nan(v) && !v[51];
  endfunction

  function automatic logic [3:0] fp_order(input logic [63:0] a, input logic [63:0] b);
    logic mag_lt;
    mag_lt = a[62:0] < b[62:0];
    if (is_nan(a) || is_nan(b))
      return fp_cmp_cvt_pkg::CC_UN;
    if ((a[62:0] == 63'h0 && b[62:0] == 63'h0) || a == b)
      return fp_cmp_cvt_pkg::CC_EQ;
    if (a[63] != b[63])
      return a[63] ? fp_cmp_cvt_pkg::CC_LT : fp_cmp_cvt_pkg::CC_GT;
    if (a[63] ^ mag_lt)
      return fp_cmp_cvt_pkg::CC_LT;
    return fp_cmp_cvt_pkg::CC_GT;
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [31:0]          stat_r;
  logic [31:0]          stat_nxt;
  logic [fp_cmp_cvt_pkg::EVT_W-1:0] evt_r;
  logic [fp_cmp_cvt_pkg::EVT_W-1:0] evt_nxt;
  logic [fp_cmp_cvt_pkg::EVT_W-1:0] mask_r;
  logic [63:0]          last_res_r;

  wire [9:0] xo       = i_instr[10:1];
  wire       prim_ok  = i_issue_valid && (i_instr[31:26] == fp_cmp_cvt_pkg::OPC_PRIMARY);
  wire       dec_ocmp = prim_ok && (xo == fp_cmp_cvt_pkg::XO_CMP_ORD);
  wire       dec_ucmp = prim_ok && (xo == fp_cmp_cvt_pkg::XO_CMP_UNORD);
  wire       dec_dw   = prim_ok && (xo == fp_cmp_cvt_pkg::XO_CVT_DW);
  wire       dec_dwz  = prim_ok && (xo == fp_cmp_cvt_pkg::XO_CVT_DWZ);
  wire       dec_w    = prim_ok && (xo == fp_cmp_cvt_pkg::XO_CVT_W);
  wire       do_cmp   = dec_ocmp || dec_ucmp;
  wire       do_cvtd  = (dec_dw || dec_dwz) && IS_64BIT;
  wire       do_cvt   = do_cvtd || dec_w;
  // anything else issued here is refused, so the core never hangs on it
  wire       illegal  = i_issue_valid && !(do_cmp || do_cvt);
  wire       rec_bit  = i_instr[0];

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  wire       signaling_not_a_number_any = is_signaling_not_a_number(i_src_a) || is_signaling_not_a_number(i_src_b);
  wire       nan_any  = is_nan(i_src_a) || is_nan(i_src_b);
  wire       quiet_not_a_number_any = nan_any && !(is_signaling_not_a_number(i_src_a) && (is_signaling_not_a_number(i_src_b) || !is_nan(i_src_b)))
                        && !(is_signaling_not_a_number(i_src_b) && !is_nan(i_src_a));
  wire [3:0] cmp_cc   = fp_order(i_src_a, i_src_b);

  // ----------------------------------------------------------------
  // convert: align into 64.64 fixed point, round, saturate
  // ----------------------------------------------------------------
  wire        cv_sign  = i_src_b[63];
  wire [10:0] cv_exp   = i_src_b[62:52];
  wire        cv_nan   = is_nan(i_src_b);
  wire        cv_big   = (cv_exp >= fp_cmp_cvt_pkg::EXP_BIG) && !cv_nan;
  wire        cv_tiny  = cv_exp < fp_cmp_cvt_pkg::EXP_SHIFT;
  wire [52:0] cv_mant  = {cv_exp != 11'h000, i_src_b[51:0]};
  wire [10:0] cv_sh    = cv_exp - fp_cmp_cvt_pkg::EXP_SHIFT;
  // mantissa sits at bits 52:0; shifting by exponent+12 puts the point at bit 64
  wire [127:0] cv_fix  = {75'h0, cv_mant} << cv_sh[6:0];
  wire [63:0] cv_int   = cv_tiny ? 64'h0 : cv_fix[127:64];
  wire        cv_rbit  = cv_tiny ? 1'b0 : cv_fix[63];
  wire        cv_stick = cv_tiny ? (i_src_b[62:0] != 63'h0) : (cv_fix[62:0] != 63'h0);
  wire [1:0]  cv_mode  = dec_dwz ? fp_cmp_cvt_pkg::RN_ZERO
                                 : stat_r[fp_cmp_cvt_pkg::RN_LSB +: 2];
  logic       cv_inc;

  always_comb
  begin
    case (cv_mode)
      fp_cmp_cvt_pkg::RN_NEAR: cv_inc = cv_rbit && (cv_stick || cv_int[0]);
      fp_cmp_cvt_pkg::RN_ZERO: cv_inc = 1'b0;
      fp_cmp_cvt_pkg::RN_PINF: cv_inc = !cv_sign && (cv_rbit || cv_stick);
      fp_cmp_cvt_pkg::RN_MINF: cv_inc = cv_sign && (cv_rbit || cv_stick);
      default:                 cv_inc = 1'b0;
    endcase
  end

  wire [64:0] cv_mag   = {1'b0, cv_int} + {64'h0, cv_inc};
  wire [63:0] cv_neg   = (~cv_mag[63:0]) + 64'h1;
  wire [63:0] cv_sres  = cv_sign ? cv_neg : cv_mag[63:0];
  // negative side reaches one further than positive: -2**63 and -2**31 fit
  wire        ovf64    = cv_big || (cv_sign ? (cv_mag[64] || (cv_mag[63] && cv_mag[62:0] != 63'h0))
                                            : (cv_mag[64:63] != 2'h0));
  wire        ovf32    = cv_big || (cv_sign ? ((cv_mag[64:32] != 33'h0) ||
                                               (cv_mag[31] && cv_mag[30:0] != 31'h0))
                                            : (cv_mag[64:31] != 34'h0));
  wire        cv_inv   = cv_nan || (dec_w ? ovf32 : ovf64);
  wire [63:0] res64    = cv_nan ? fp_cmp_cvt_pkg::MIN64
                       : ovf64  ? (cv_sign ? fp_cmp_cvt_pkg::MIN64 : fp_cmp_cvt_pkg::MAX64)
                       : cv_sres;
  wire [31:0] res32    = cv_nan ? fp_cmp_cvt_pkg::MIN32
                       : ovf32  ? (cv_sign ? fp_cmp_cvt_pkg::MIN32 : fp_cmp_cvt_pkg::MAX32)
                       : cv_sres[31:0];
  // upper word of a word convert has no defined value; zero keeps it repeatable
  wire [63:0] cv_res   = dec_w ? {32'h0, res32} : res64;
  wire        cv_fi    = !cv_inv && (cv_rbit || cv_stick);
  wire        cv_fr    = !cv_inv && cv_inc;

  // ----------------------------------------------------------------
  // status register update
  // ----------------------------------------------------------------
  wire        wr_stat  = i_reg_wr && (i_reg_addr == fp_cmp_cvt_pkg::OFS_STATUS);
  wire [31:0] stat_base = wr_stat ? i_reg_wdata : stat_r;
  logic [31:0] stat_upd;

  // hardware sets land on top of a same-cycle software write, so none is lost
  always_comb
  begin
    stat_upd = stat_base;
    if (do_cmp)
    begin
      stat_upd[fp_cmp_cvt_pkg::FP_CONDITION_CODE_LSB +: 4] = cmp_cc;
      if (signaling_not_a_number_any)
        stat_upd[fp_cmp_cvt_pkg::B_SIGNALING_NOT_A_NUMBER_INVALID_FLAG] = 1'b1;
      if (dec_ocmp && (quiet_not_a_number_any || (signaling_not_a_number_any && !stat_base[fp_cmp_cvt_pkg::B_VE])))
        stat_upd[fp_cmp_cvt_pkg::B_INVALID_COMPARE_FLAG] = 1'b1;
    end
    if (do_cvt)
    begin
      stat_upd[fp_cmp_cvt_pkg::B_FR] = cv_fr;
      stat_upd[fp_cmp_cvt_pkg::B_FI] = cv_fi;
      if (cv_fi)
        stat_upd[fp_cmp_cvt_pkg::B_XX] = 1'b1;
      if (is_signaling_not_a_number(i_src_b))
        stat_upd[fp_cmp_cvt_pkg::B_SIGNALING_NOT_A_NUMBER_INVALID_FLAG] = 1'b1;
      if (cv_inv)
        stat_upd[fp_cmp_cvt_pkg::B_INVALID_CONVERT_FLAG] = 1'b1;
    end
  end

  wire        new_exc  = ((stat_upd & ~stat_base & fp_cmp_cvt_pkg::EXC_MASK) != 32'h0);
  wire        sum_vx   = ((stat_upd & fp_cmp_cvt_pkg::VX_SRC_MASK) != 32'h0);
  wire        sum_fex  = (sum_vx && stat_upd[fp_cmp_cvt_pkg::B_VE]) ||
                         (stat_upd[fp_cmp_cvt_pkg::B_OX] && stat_upd[fp_cmp_cvt_pkg::B_OE]) ||
                         (stat_upd[fp_cmp_cvt_pkg::B_UX] && stat_upd[fp_cmp_cvt_pkg::B_UE]) ||
                         (stat_upd[fp_cmp_cvt_pkg::B_ZX] && stat_upd[fp_cmp_cvt_pkg::B_ZE]) ||
                         (stat_upd[fp_cmp_cvt_pkg::B_XX] && stat_upd[fp_cmp_cvt_pkg::B_XE]);

  always_comb
  begin
    stat_nxt = stat_upd;
    stat_nxt[fp_cmp_cvt_pkg::B_FX]  = stat_upd[fp_cmp_cvt_pkg::B_FX] || new_exc;
    stat_nxt[fp_cmp_cvt_pkg::B_VX]  = sum_vx;
    stat_nxt[fp_cmp_cvt_pkg::B_FEX] = sum_fex;
  end

  // ----------------------------------------------------------------
  // events, mask and register port
  // ----------------------------------------------------------------
  wire [fp_cmp_cvt_pkg::EVT_W-1:0] ev_set = {
    illegal,
    do_cvt && cv_fi,
    do_cvt && cv_inv,
    dec_ocmp && (stat_upd[fp_cmp_cvt_pkg::B_INVALID_COMPARE_FLAG] && !stat_base[fp_cmp_cvt_pkg::B_INVALID_COMPARE_FLAG]),
    (do_cmp && signaling_not_a_number_any) || (do_cvt && is_signaling_not_a_number(i_src_b))
  };
  wire wr_evt  = i_reg_wr && (i_reg_addr == fp_cmp_cvt_pkg::OFS_EVT);
  wire wr_mask = i_reg_wr && (i_reg_addr == fp_cmp_cvt_pkg::OFS_MASK);
  wire [fp_cmp_cvt_pkg::EVT_W-1:0] evt_clr = wr_evt ? i_reg_wdata[fp_cmp_cvt_pkg::EVT_W-1:0] : '0;
  wire [fp_cmp_cvt_pkg::EVT_W-1:0] mask_nxt = wr_mask ? i_reg_wdata[fp_cmp_cvt_pkg::EVT_W-1:0] : mask_r;

  // set wins over write-one-to-clear in the same cycle
  assign evt_nxt = (evt_r & ~evt_clr) | ev_set;

  logic [31:0] rd_mux;
  always_comb
  begin
    case (i_reg_addr)
      fp_cmp_cvt_pkg::OFS_STATUS: rd_mux = stat_r;
      fp_cmp_cvt_pkg::OFS_EVT:    rd_mux = {{(32-fp_cmp_cvt_pkg::EVT_W){1'b0}}, evt_r};
      fp_cmp_cvt_pkg::OFS_MASK:   rd_mux = {{(32-fp_cmp_cvt_pkg::EVT_W){1'b0}}, mask_r};
      fp_cmp_cvt_pkg::OFS_RES_LO: rd_mux = last_res_r[31:0];
      fp_cmp_cvt_pkg::OFS_RES_HI: rd_mux = last_res_r[63:32];
      default:                    rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      stat_r     <= fp_cmp_cvt_pkg::STAT_RST;
      evt_r      <= fp_cmp_cvt_pkg::EVT_RST;
      mask_r     <= fp_cmp_cvt_pkg::EVT_RST;
      last_res_r <= 64'h0;
    end
    else
    begin
      stat_r <= stat_nxt;
      evt_r  <= evt_nxt;
      mask_r <= mask_nxt;
      if (do_cvt)
        last_res_r <= cv_res;
    end
  end

  // ----------------------------------------------------------------
  // output registers, one cycle after issue
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_reg_rdata  <= 32'h0000_0000;
      o_done       <= 1'b0;
      o_illegal    <= 1'b0;
      o_result_we  <= 1'b0;
      o_result_idx <= 5'h00;
      o_result     <= 64'h0;
      o_cc_we      <= 1'b0;
      o_cc_field   <= 3'h0;
      o_cc_data    <= 4'h0;
      o_cr1_we     <= 1'b0;
      o_cr1_data   <= 4'h0;
      o_fp_status  <= fp_cmp_cvt_pkg::STAT_RST;
      o_irq        <= 1'b0;
    end
    else
    begin
      o_reg_rdata  <= i_reg_rd ? rd_mux : 32'h0000_0000;
      o_done       <= i_issue_valid;
      o_illegal    <= illegal;
      o_result_we  <= do_cvt;
      o_result_idx <= i_instr[25:21];
      o_result     <= do_cvt ? cv_res : 64'h0;
      o_cc_we      <= do_cmp;
      o_cc_field   <= i_instr[25:23];
      o_cc_data    <= do_cmp ? cmp_cc : 4'h0;
      o_cr1_we     <= do_cvt && rec_bit;
      o_cr1_data   <= {stat_nxt[fp_cmp_cvt_pkg::B_FX], stat_nxt[fp_cmp_cvt_pkg::B_FEX],
                       stat_nxt[fp_cmp_cvt_pkg::B_VX], stat_nxt[fp_cmp_cvt_pkg::B_OX]};
      o_fp_status  <= stat_nxt;
      o_irq        <= ((evt_nxt & mask_nxt) != '0);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  AST_CMP_ANSWER: assert property (dec_ocmp || dec_ucmp |=> o_cc_we && o_done)
    else $error("compare did not write a condition field");
  AST_UCMP_ANSWER: assert property (dec_ucmp |=> o_cc_we && !o_result_we)
    else $error("unordered compare answered wrongly");
  AST_CC_FIELD: assert property (do_cmp |=> o_cc_field == $past(i_instr[25:23]) &&
                                 o_fp_status[15:12] == o_cc_data)
    else $error("condition field or code copy mismatch");
  AST_NAN_UNORD: assert property (do_cmp && nan_any |=> o_cc_data == fp_cmp_cvt_pkg::CC_UN)
    else $error("NaN compare not unordered");
  AST_SIGNALING_NOT_A_NUMBER_FLAG: assert property (do_cmp && signaling_not_a_number_any |=> o_fp_status[fp_cmp_cvt_pkg::B_SIGNALING_NOT_A_NUMBER_INVALID_FLAG])
    else $error("signaling NaN flag not set");
  AST_OCMP_INVALID_COMPARE_FLAG: assert property (dec_ocmp && (quiet_not_a_number_any ||
                                  (signaling_not_a_number_any && !stat_base[fp_cmp_cvt_pkg::B_VE]))
                                  |=> stat_r[fp_cmp_cvt_pkg::B_INVALID_COMPARE_FLAG] &&
                                  (o_fp_status[fp_cmp_cvt_pkg::B_FX] || $past(stat_base[fp_cmp_cvt_pkg::B_INVALID_COMPARE_FLAG])))
    else $error("invalid compare flag missing");
  AST_UCMP_NO_VC: assert property (dec_ucmp && !wr_stat && !stat_r[fp_cmp_cvt_pkg::B_INVALID_COMPARE_FLAG]
                                   |=> !stat_r[fp_cmp_cvt_pkg::B_INVALID_COMPARE_FLAG])
    else $error("unordered compare set invalid compare");
  AST_CC_ONEHOT: assert property (o_cc_we |-> $onehot(o_cc_data))
    else $error("condition code not one-hot");
  AST_DW_SAT: assert property (do_cvtd && !cv_nan && cv_big
                               |=> o_result == ($past(cv_sign) ? fp_cmp_cvt_pkg::MIN64
                                                               : fp_cmp_cvt_pkg::MAX64))
    else $error("doubleword saturation wrong");
  AST_DWZ_TRUNC: assert property (dec_dwz && IS_64BIT && !cv_sign && !cv_inv
                                  |=> o_result == $past(cv_int) && !o_fp_status[fp_cmp_cvt_pkg::B_FR])
    else $error("round toward zero convert rounded up");
  AST_W_SAT: assert property (dec_w && !cv_nan && !cv_sign && ovf32
                              |=> o_result[31:0] == fp_cmp_cvt_pkg::MAX32 && o_result_we)
    else $error("word saturation wrong");
  AST_NAN_CVT: assert property (do_cvt && cv_nan |=> o_fp_status[fp_cmp_cvt_pkg::B_INVALID_CONVERT_FLAG] &&
                                (o_result[63] || o_result[31:0] == fp_cmp_cvt_pkg::MIN32))
    else $error("NaN convert not flagged or not most negative");
  AST_CR1_COPY: assert property (do_cvt && rec_bit |=> o_cr1_we &&
                                 o_cr1_data == o_fp_status[31:28])
    else $error("record copy into field 1 wrong");
  AST_ILLEGAL_32: assert property (!IS_64BIT && (dec_dw || dec_dwz)
                                   |=> o_illegal && !o_result_we)
    else $error("doubleword convert accepted on 32-bit build");

  COV_OCMP_QUIET_NOT_A_NUMBER: cover property (dec_ocmp && quiet_not_a_number_any ##1 o_cc_we);
  COV_CVT_ROUND: cover property (dec_dw && cv_inc ##1 o_result_we);
  COV_W_NEG_SAT: cover property (dec_w && ovf32 && cv_sign);
  COV_IRQ:       cover property (ev_set != '0 ##1 o_irq);

endmodule // fp_compare_convert_unit

// ---- fp_cmp_cvt_pkg.sv ----
// constants for the floating-point compare and convert unit
package fp_cmp_cvt_pkg;

  // ----------------------------------------------------------------
  // instruction encoding
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_PRIMARY  = 6'h3F;
  localparam logic [9:0] XO_CMP_ORD   = 10'h020;
  localparam logic [9:0] XO_CMP_UNORD = 10'h000;
  localparam logic [9:0] XO_CVT_DW    = 10'h32E;
  localparam logic [9:0] XO_CVT_DWZ   = 10'h32F;
  localparam logic [9:0] XO_CVT_W     = 10'h00E;

  // ----------------------------------------------------------------
  // fp_status_control_reg bit positions (bit 31 is the leftmost flag)
  // ----------------------------------------------------------------
  localparam int B_FX      = 31;
  localparam int B_FEX     = 30;
  localparam int B_VX      = 29;
  localparam int B_OX      = 28;
  localparam int B_UX      = 27;
  localparam int B_ZX      = 26;
  localparam int B_XX      = 25;
  localparam int B_SIGNALING_NOT_A_NUMBER_INVALID_FLAG  = 24;
  localparam int B_INVALID_COMPARE_FLAG    = 19;
  localparam int B_FR      = 18;
  localparam int B_FI      = 17;
  localparam int FP_CONDITION_CODE_LSB  = 12;
  localparam int B_INVALID_CONVERT_FLAG   = 8;
  localparam int B_VE      = 7;
  localparam int B_OE      = 6;
  localparam int B_UE      = 5;
  localparam int B_ZE      = 4;
  localparam int B_XE      = 3;
  localparam int RN_LSB    = 0;
  localparam logic [31:0] EXC_MASK    = 32'h1FF8_0700;
  localparam logic [31:0] VX_SRC_MASK = 32'h01F8_0700;
  localparam logic [31:0] STAT_RST    = 32'h0000_0000;

  // condition code, one-hot: less, greater, equal, unordered
  localparam logic [3:0] CC_LT = 4'h8;
  localparam logic [3:0] CC_GT = 4'h4;
  localparam logic [3:0] CC_EQ = 4'h2;
  localparam logic [3:0] CC_UN = 4'h1;

  // rounding_control_field encodings
  localparam logic [1:0] RN_NEAR = 2'h0;
  localparam logic [1:0] RN_ZERO = 2'h1;
  localparam logic [1:0] RN_PINF = 2'h2;
  localparam logic [1:0] RN_MINF = 2'h3;

  // ----------------------------------------------------------------
  // double-precision layout and integer limits
  // ----------------------------------------------------------------
  localparam logic [10:0] EXP_ALL   = 11'h7FF;
  localparam logic [10:0] EXP_BIG   = 11'h43F;
  localparam logic [10:0] EXP_SHIFT = 11'h3F3;
  localparam logic [63:0] MAX64     = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] MIN64     = 64'h8000_0000_0000_0000;
  localparam logic [31:0] MAX32     = 32'h7FFF_FFFF;
  localparam logic [31:0] MIN32     = 32'h8000_0000;

  // ----------------------------------------------------------------
  // register port map and event bits
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_EVT      = 8'h04;
  localparam logic [7:0] OFS_MASK     = 8'h08;
  localparam logic [7:0] OFS_RES_LO   = 8'h0C;
  localparam logic [7:0] OFS_RES_HI   = 8'h10;
  localparam int         EVT_W        = 5;
  localparam int         EV_SIGNALING_NOT_A_NUMBER      = 0;
  localparam int         EV_VC        = 1;
  localparam int         EV_CVI       = 2;
  localparam int         EV_INEXACT   = 3;
  localparam int         EV_ILLEGAL   = 4;
  localparam logic [4:0] EVT_RST      = 5'h00;

endpackage

// ---- fp_issue_model.sv ----
// issue-side model of the core: one instruction per call, operands scrambled after release
module fp_issue_model (
  input  wire logic        i_core_clk,
  output logic             o_issue_valid,
  output logic      [31:0] o_instr,
  output logic      [63:0] o_src_a,
  output logic      [63:0] o_src_b
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {o_issue_valid, o_instr, o_src_a, o_src_b} = '0;
  // inverted leftovers so a unit that samples late never sees the old operand
  task automatic issue(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
    @(posedge i_core_clk);
    o_issue_valid <= 1'b1;
    o_instr       <= ins;
    o_src_a       <= a;
    o_src_b       <= b;
    @(posedge i_core_clk);
    o_issue_valid <= 1'b0;
    o_instr       <= ~ins;
    o_src_a       <= ~a;
    o_src_b       <= ~b;
    #1;
  endtask
endmodule // fp_issue_model

// ---- test_fp_compare_convert_unit.sv ----
// self-checking bench for the compare and convert unit
module test_fp_compare_convert_unit;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, valid, done, ill, rwe, ccwe, c1we, irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, instr, st;
  logic [63:0] a, b, res;
  logic [4:0] ridx;
  logic [2:0] ccf;
  logic [3:0] ccd, c1d;
  logic ill32;
  int fail_count = 0, checks = 0;
  always #12.5 clk = ~clk;
  fp_issue_model model (.i_core_clk(clk), .o_issue_valid(valid), .o_instr(instr), .o_src_a(a), .o_src_b(b));
  fp_compare_convert_unit dut (.i_core_clk(clk), .i_sys_rst(rst), .i_issue_valid(valid), .i_instr(instr),
    .i_src_a(a), .i_src_b(b), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_done(done), .o_illegal(ill), .o_result_we(rwe), .o_result_idx(ridx),
    .o_result(res), .o_cc_we(ccwe), .o_cc_field(ccf), .o_cc_data(ccd), .o_cr1_we(c1we),
    .o_cr1_data(c1d), .o_fp_status(st), .o_irq(irq));
  // 32-bit build beside the main one: doubleword converts must be refused there
  fp_compare_convert_unit #(.IS_64BIT(1'b0)) dut32 (.i_core_clk(clk), .i_sys_rst(rst), .i_issue_valid(valid),
    .i_instr(instr), .i_src_a(a), .i_src_b(b), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(), .o_done(), .o_illegal(ill32), .o_result_we(), .o_result_idx(), .o_result(),
    .o_cc_we(), .o_cc_field(), .o_cc_data(), .o_cr1_we(), .o_cr1_data(), .o_fp_status(), .o_irq());
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk);
    addr <= ad; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic cmp(input logic [9:0] xo, input logic [63:0] x, y, input logic [3:0] cc, input logic vc, sn);
    wr_reg(fp_cmp_cvt_pkg::OFS_STATUS, 32'h0);
    model.issue({fp_cmp_cvt_pkg::OPC_PRIMARY, 3'h5, 12'h000, xo, 1'b0}, x, y);
    chk("done", 1, done);
    chk("cc_we", 1, ccwe);
    chk("cc_field", 5, ccf);
    chk("cc_data", cc, ccd);
    chk("fp_condition_code", cc, st[15:12]);
    chk("invalid_compare_flag", vc, st[fp_cmp_cvt_pkg::B_INVALID_COMPARE_FLAG]);
    chk("signaling_not_a_number_invalid_flag", sn, st[fp_cmp_cvt_pkg::B_SIGNALING_NOT_A_NUMBER_INVALID_FLAG]);
  endtask
  task automatic cvt(input logic [9:0] xo, input logic [1:0] rn, input logic [63:0] x, e, input logic fr, fi, cvi);
    wr_reg(fp_cmp_cvt_pkg::OFS_STATUS, {30'h0, rn});
    model.issue({fp_cmp_cvt_pkg::OPC_PRIMARY, 5'h07, 10'h000, xo, 1'b1}, 64'h0, x);
    chk("result_we", 1, rwe);
    chk("result_idx", 7, ridx);
    chk("result", e, res);
    chk("fr", fr, st[fp_cmp_cvt_pkg::B_FR]);
    chk("fi", fi, st[fp_cmp_cvt_pkg::B_FI]);
    chk("invalid_convert_flag", cvi, st[fp_cmp_cvt_pkg::B_INVALID_CONVERT_FLAG]);
    chk("cr1_we", 1, c1we);
    chk("cr1_data", {fi | cvi, 1'b0, cvi, 1'b0}, c1d);
    chk("illegal32", xo != 10'h00E, ill32);
  endtask
  // refused opcode raises the illegal event, then mask and clear drop the interrupt
  task automatic irq_scn();
    wr_reg(fp_cmp_cvt_pkg::OFS_EVT, 32'h1F);
    wr_reg(fp_cmp_cvt_pkg::OFS_MASK, 32'h1F);
    wr_reg(fp_cmp_cvt_pkg::OFS_STATUS, 32'h2);
    model.issue({fp_cmp_cvt_pkg::OPC_PRIMARY, 15'h0, 10'h3FF, 1'b0}, 64'h0, 64'h0);
    chk("illegal", 1, ill);
    rd_chk(fp_cmp_cvt_pkg::OFS_EVT, 32'h10);
    chk("irq", 1, irq);
    chk("status", 32'h2, st);
    wr_reg(fp_cmp_cvt_pkg::OFS_MASK, 32'h0);
    rd_chk(fp_cmp_cvt_pkg::OFS_MASK, 32'h0);
    chk("irq", 0, irq);
    wr_reg(fp_cmp_cvt_pkg::OFS_EVT, 32'h10);
    rd_chk(fp_cmp_cvt_pkg::OFS_EVT, 32'h0);
    rd_chk(8'hFC, 32'h0);
  endtask
  task automatic give_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #(25 * 3000);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cmp(10'h020, 64'h3FF0_0000_0000_0000, 64'h4000_0000_0000_0000, 4'h8, 0, 0);
    cmp(10'h000, 64'h4000_0000_0000_0000, 64'h3FF0_0000_0000_0000, 4'h4, 0, 0);
    cmp(10'h020, 64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000, 4'h2, 0, 0);
    cmp(10'h020, 64'h7FF8_0000_0000_0000, 64'h3FF0_0000_0000_0000, 4'h1, 1, 0);
    cmp(10'h020, 64'h3FF0_0000_0000_0000, 64'h7FF0_0000_0000_0001, 4'h1, 1, 1);
    cmp(10'h000, 64'h7FF0_0000_0000_0001, 64'h3FF0_0000_0000_0000, 4'h1, 0, 1);
    cmp(10'h000, 64'h7FF8_0000_0000_0000, 64'h7FF8_0000_0000_0000, 4'h1, 0, 0);
    cvt(10'h32E, 2'h0, 64'h4004_0000_0000_0000, 64'h2, 0, 1, 0);
    cvt(10'h32E, 2'h2, 64'h4004_0000_0000_0000, 64'h3, 1, 1, 0);
    cvt(10'h32F, 2'h2, 64'h4004_0000_0000_0000, 64'h2, 0, 1, 0);
    cvt(10'h32E, 2'h0, 64'h43F0_0000_0000_0000, fp_cmp_cvt_pkg::MAX64, 0, 0, 1);
    cvt(10'h32F, 2'h1, 64'hC3F0_0000_0000_0000, fp_cmp_cvt_pkg::MIN64, 0, 0, 1);
    cvt(10'h32E, 2'h0, 64'h7FF8_0000_0000_0000, fp_cmp_cvt_pkg::MIN64, 0, 0, 1);
    cvt(10'h00E, 2'h3, 64'h4004_0000_0000_0000, 64'h2, 0, 1, 0);
    cvt(10'h00E, 2'h0, 64'hC270_0000_0000_0000, {32'h0, fp_cmp_cvt_pkg::MIN32}, 0, 0, 1);
    cvt(10'h00E, 2'h0, 64'h4270_0000_0000_0000, {32'h0, fp_cmp_cvt_pkg::MAX32}, 0, 0, 1);
    cvt(10'h32E, 2'h1, 64'hC004_0000_0000_0000, 64'hFFFF_FFFF_FFFF_FFFE, 0, 1, 0);
    cvt(10'h00E, 2'h3, 64'hC004_0000_0000_0000, 64'h0000_0000_FFFF_FFFD, 1, 1, 0);
    cvt(10'h00E, 2'h0, 64'h7FF8_0000_0000_0000, {32'h0, fp_cmp_cvt_pkg::MIN32}, 0, 0, 1);
    irq_scn();
    give_verdict();
  end
endmodule // test_fp_compare_convert_unit
